// File: hw/alm_alert_limit_monitor.sv
// Alert, limit compare, status flags and identity registers of the monitor
// Notes on behaviour
// - Shunt over enable: alert when a finished shunt result exceeds threshold.
// - Shunt under enable: alert when a finished shunt result is below threshold.
// - Bus over enable: alert when a finished bus result exceeds threshold.
// - Bus under enable: alert when a finished bus result is below threshold.
// - Power over enable: alert when the power result exceeds threshold.
// - Conversion alert enable: alert whenever the conversion done flag sets.
// - Several limit enables: only the highest bit position is acted on.
// - One limit function at a time, plus optional conversion ready alert.
// - Source flag sets when the limit function caused the alert.
// - Hold mode: source flag clears only on a read of the mask register.
// - Follow mode: source flag clears after next conversion without fault.
// - Done flag sets once the whole conversion cycle has finished.
// - Done flag clears on non power-down config write or mask read.
// - Mode codes with both low bits zero mean power-down.
// - Overflow flag sets whenever an arithmetic overflow is reported.
// - Level bit one: active-high open collector; zero: active-low, default.
// - Hold select one: hold mode; zero: follow mode, the default.
// - Follow mode: pin and flag go idle once the fault is gone.
// - Hold mode: pin and flag stay active until the mask register is read.
// - Selected quantity is compared with the 16-bit writable threshold.
// - Read-only 16-bit maker identification register with fixed code.
// - Die register: 12-bit type code high, 4-bit revision low.
`timescale 1ns/1ps
`default_nettype none
module alm_alert_limit_monitor #(
   // Identity codes below are arbitrary neutral values
   parameter logic [15:0] MAKER_CODE = 16'hA5C3,
   parameter logic [11:0] DIE_TYPE   = 12'h5A1,
   parameter logic [3:0]  DIE_REV    = 4'h2
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire alm_pkg::alm_reg_req_t i_req,
   output logic [alm_pkg::ALM_DW-1:0] o_rdata,
   input  wire logic                 i_cfg_wr,
   input  wire logic [2:0]           i_cfg_mode,
   input  wire alm_pkg::alm_meas_t   i_meas,
   output logic                      o_alert_out,
   output logic                      o_alert_oe
);
   import alm_pkg::*;

   logic [15:0] mask_ff;
   logic [15:0] nxt_mask;
   logic [15:0] thr_ff;
   logic [15:0] nxt_thr;
   logic        src_flag_ff;
   logic        nxt_src_flag;
   logic        done_flag_ff;
   logic        nxt_done_flag;
   logic        ovf_flag_ff;
   logic        nxt_ovf_flag;
   logic        oe_ff;
   logic        nxt_oe;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;

   // Register decode
   wire mask_hit = (i_req.addr == ALM_ADDR_MASK);
   wire thr_hit  = (i_req.addr == ALM_ADDR_THR);
   wire mask_wr  = i_req.wr & mask_hit;
   wire thr_wr   = i_req.wr & thr_hit;
   wire mask_rd  = i_req.rd & mask_hit;

   // Mode fields
   wire shunt_ov_en = mask_ff[ALM_B_SHUNT_OV];
   wire shunt_un_en = mask_ff[ALM_B_SHUNT_UN];
   wire bus_ov_en   = mask_ff[ALM_B_BUS_OV];
   wire bus_un_en   = mask_ff[ALM_B_BUS_UN];
   wire power_ov_en = mask_ff[ALM_B_POWER_OV];
   wire conv_en     = mask_ff[ALM_B_CONV_EN];
   wire level_hi    = mask_ff[ALM_B_LEVEL];
   wire hold_mode   = mask_ff[ALM_B_HOLD];

   // Highest set enable wins; lower ones are masked out
   wire sel_so = shunt_ov_en;
   wire sel_su = shunt_un_en & ~shunt_ov_en;
   wire sel_bo = bus_ov_en & ~shunt_ov_en & ~shunt_un_en;
   wire sel_bu = bus_un_en & ~(|mask_ff[ALM_B_SHUNT_OV:ALM_B_BUS_OV]);
   wire sel_po = power_ov_en
               & ~(|mask_ff[ALM_B_SHUNT_OV:ALM_B_BUS_UN]);

   // Comparators against the threshold
   wire s_gt = $signed(i_meas.shunt_val) > $signed(thr_ff);
   wire s_lt = $signed(i_meas.shunt_val) < $signed(thr_ff);
   wire b_gt = i_meas.bus_val > thr_ff;
   wire b_lt = i_meas.bus_val < thr_ff;
   wire p_gt = i_meas.power_val > thr_ff;

   // A compare only counts when its own quantity has just been finished
   wire shunt_evt = (sel_so | sel_su) & i_meas.shunt_done;
   wire bus_evt   = (sel_bo | sel_bu) & i_meas.bus_done;
   wire power_evt = sel_po & i_meas.power_done;
   wire lim_evt   = shunt_evt | bus_evt | power_evt;

   wire f_so  = sel_so & s_gt;
   wire f_su  = sel_su & s_lt;
   wire f_bo  = sel_bo & b_gt;
   wire f_bu  = sel_bu & b_lt;
   wire f_po  = sel_po & p_gt;
   wire fault = lim_evt & (f_so | f_su | f_bo | f_bu | f_po);

   // Power-down codes leave the done flag alone
   wire cfg_clr = i_cfg_wr & (i_cfg_mode[1:0] != ALM_MODE_OFF);

   // Flag updates: a setting event always beats a clear in the same cycle
   always_comb begin
      nxt_src_flag = src_flag_ff;
      if (fault) begin
         nxt_src_flag = 1'b1;
      end else if (hold_mode) begin
         if (mask_rd) begin
            nxt_src_flag = 1'b0;
         end
      end else if (lim_evt) begin
         nxt_src_flag = 1'b0;
      end
   end

   always_comb begin
      nxt_done_flag = done_flag_ff;
      if (i_meas.cycle_done) begin
         nxt_done_flag = 1'b1;
      end else if (cfg_clr | mask_rd) begin
         nxt_done_flag = 1'b0;
      end
   end

   // Overflow has no other clear; a mask read releases it here
   assign nxt_ovf_flag = i_meas.math_ovf | (ovf_flag_ff & ~mask_rd);

   // Only enables and mode bits take host writes
   assign nxt_mask = mask_wr ? (i_req.wdata & ALM_MASK_WR)
                             : mask_ff;
   assign nxt_thr  = thr_wr ? i_req.wdata : thr_ff;

   // Pin pulled low when active-low alert is on, or when active-high idle
   wire nxt_active = nxt_src_flag
                   | (nxt_mask[ALM_B_CONV_EN] & nxt_done_flag);
   assign nxt_oe = nxt_active ^ nxt_mask[ALM_B_LEVEL];

   // Read mux; flags are reported before a read clears them
   wire [15:0] mask_view = mask_ff
                         | ({15'h0000, src_flag_ff} << ALM_B_SRC_FLAG)
                         | ({15'h0000, done_flag_ff} << ALM_B_DONE_FLAG)
                         | ({15'h0000, ovf_flag_ff} << ALM_B_OVF_FLAG);
   wire [15:0] die_view  = {DIE_TYPE, DIE_REV};

   always_comb begin
      nxt_rdata = rdata_ff;
      if (i_req.rd) begin
         case (i_req.addr)
            ALM_ADDR_MASK:  nxt_rdata = mask_view;
            ALM_ADDR_THR:   nxt_rdata = thr_ff;
            ALM_ADDR_MAKER: nxt_rdata = MAKER_CODE;
            ALM_ADDR_DIE:   nxt_rdata = die_view;
            default:        nxt_rdata = ALM_RST_16;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_ff <= ALM_RST_16;
         thr_ff  <= ALM_RST_16;
      end else begin
         mask_ff <= nxt_mask;
         thr_ff  <= nxt_thr;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         src_flag_ff  <= 1'b0;
         done_flag_ff <= 1'b0;
         ovf_flag_ff  <= 1'b0;
      end else begin
         src_flag_ff  <= nxt_src_flag;
         done_flag_ff <= nxt_done_flag;
         ovf_flag_ff  <= nxt_ovf_flag;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         oe_ff    <= 1'b0;
         rdata_ff <= ALM_RST_16;
      end else begin
         oe_ff    <= nxt_oe;
         rdata_ff <= nxt_rdata;
      end
   end

   // Open collector: the pin is only ever pulled low
   assign o_alert_out = 1'b0;
   assign o_alert_oe  = oe_ff;
   assign o_rdata     = rdata_ff;

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   wire active_now = src_flag_ff | (conv_en & done_flag_ff);

   sequence s_fault_in_hold;
      hold_mode && fault && !mask_wr;
   endsequence

   sequence s_quiet_cycle;
      !mask_rd && !mask_wr && !lim_evt;
   endsequence

   sequence s_mask_read_clean;
      hold_mode && mask_rd && !lim_evt && !i_meas.cycle_done && !mask_wr;
   endsequence

   a_shunt_over_set: assert property (
      lim_evt && sel_so && s_gt |=> src_flag_ff)
      else $error("shunt over limit did not set source flag");

   a_shunt_under_set: assert property (
      lim_evt && sel_su && s_lt |=> src_flag_ff)
      else $error("shunt under limit did not set source flag");

   a_bus_over_set: assert property (
      sel_bo && i_meas.bus_done && b_gt |=> src_flag_ff)
      else $error("bus over limit did not set source flag");

   a_bus_under_set: assert property (
      sel_bu && i_meas.bus_done && b_lt |=> src_flag_ff)
      else $error("bus under limit did not set source flag");

   a_power_over_set: assert property (
      sel_po && i_meas.power_done && p_gt |=> src_flag_ff)
      else $error("power over limit did not set source flag");

   a_conv_ready_pin: assert property (
      conv_en && i_meas.cycle_done && !mask_wr
      |=> o_alert_oe == !level_hi)
      else $error("conversion ready did not drive alert pin");

   a_priority_mask: assert property (
      shunt_ov_en && bus_ov_en && !hold_mode && !mask_wr
      && i_meas.bus_done && b_gt && !i_meas.shunt_done
      && !src_flag_ff |=> !src_flag_ff)
      else $error("lower priority function raised source flag");

   a_latch_hold: assert property (
      s_fault_in_hold ##1 s_quiet_cycle [*2] |=> src_flag_ff)
      else $error("held alert flag dropped without mask read");

   a_latch_release: assert property (
      s_mask_read_clean |=> !src_flag_ff ##1 (!src_flag_ff
         || $past(lim_evt)))
      else $error("mask read did not release held flag");

   a_follow_clear: assert property (
      !hold_mode && lim_evt && !fault && !mask_wr |=> !src_flag_ff)
      else $error("follow mode flag kept after clean conversion");

   a_follow_pin_idle: assert property (
      !hold_mode && !conv_en && lim_evt && !fault && !mask_wr
      |=> o_alert_oe == level_hi)
      else $error("follow mode pin not idle after clean conversion");

   a_done_clear: assert property (
      (cfg_clr || mask_rd) && !i_meas.cycle_done |=> !done_flag_ff)
      else $error("done flag not cleared");

   a_done_pdown_keep: assert property (
      done_flag_ff && i_cfg_wr && i_cfg_mode[1:0] == ALM_MODE_OFF
      && !i_req.rd |=> done_flag_ff)
      else $error("power-down write cleared done flag");

   a_done_set_wins: assert property (
      i_meas.cycle_done |=> done_flag_ff)
      else $error("done flag missed end of cycle");

   a_ovf_set: assert property (
      i_meas.math_ovf |=> ovf_flag_ff)
      else $error("overflow flag not set");

   a_pin_level: assert property (
      o_alert_oe == (active_now ^ level_hi))
      else $error("alert pin level disagrees with flags");

   a_read_ident: assert property (
      i_req.rd && i_req.addr == ALM_ADDR_MAKER |=> o_rdata == MAKER_CODE)
      else $error("maker code read wrong");

   a_read_die: assert property (
      i_req.rd && i_req.addr == ALM_ADDR_DIE
      |=> o_rdata == {DIE_TYPE, DIE_REV})
      else $error("die code read wrong");

   a_reserved_zero: assert property (
      i_req.rd && mask_hit |=> (o_rdata & 16'h03E0) == 16'h0000)
      else $error("reserved mask bits read nonzero");

   a_thr_write: assert property (
      thr_wr |=> thr_ff == $past(i_req.wdata))
      else $error("threshold write not stored");

   a_hold_select: assert property (
      mask_wr |=> hold_mode == $past(i_req.wdata[ALM_B_HOLD]))
      else $error("hold select not stored");

   a_ovf_keep: assert property (
      ovf_flag_ff && !mask_rd |=> ovf_flag_ff)
      else $error("overflow flag dropped without mask read");

   a_src_read_view: assert property (
      mask_rd |=> o_rdata[ALM_B_SRC_FLAG] == $past(src_flag_ff))
      else $error("source flag not reported on mask read");

   a_done_read_view: assert property (
      mask_rd |=> o_rdata[ALM_B_DONE_FLAG] == $past(done_flag_ff))
      else $error("done flag not reported on mask read");

   a_src_hold_keep: assert property (
      hold_mode && src_flag_ff && !mask_rd && !mask_wr
      |=> src_flag_ff)
      else $error("held source flag dropped");

   a_follow_read_keep: assert property (
      !hold_mode && src_flag_ff && mask_rd && !lim_evt |=> src_flag_ff)
      else $error("follow mode flag cleared by a read");

   a_thr_read_back: assert property (
      i_req.rd && thr_hit |=> o_rdata == $past(thr_ff))
      else $error("threshold read wrong");

   a_power_gated: assert property (
      power_ov_en && !sel_po && i_meas.power_done && p_gt
      && !i_meas.shunt_done && !i_meas.bus_done && !src_flag_ff
      |=> !src_flag_ff)
      else $error("masked power limit raised source flag");

   a_mask_write_clean: assert property (
      mask_wr |=> (mask_ff & ~ALM_MASK_WR) == ALM_RST_16)
      else $error("flag or reserved bits took a write");

endmodule
`default_nettype wire

// File: hw/alm_pkg.sv
// Constants, field positions and carrier types for the alert limit monitor
package alm_pkg;
   localparam int          ALM_DW          = 16;
   localparam int          ALM_AW          = 8;
   localparam logic [7:0]  ALM_ADDR_MASK   = 8'h06;
   localparam logic [7:0]  ALM_ADDR_THR    = 8'h07;
   localparam logic [7:0]  ALM_ADDR_MAKER  = 8'hFE;
   localparam logic [7:0]  ALM_ADDR_DIE    = 8'hFF;
   localparam logic [15:0] ALM_RST_16      = 16'h0000;
   // Only the six enables and the two mode bits are host writable
   localparam logic [15:0] ALM_MASK_WR     = 16'hFC03;
   localparam int          ALM_B_SHUNT_OV  = 15;
   localparam int          ALM_B_SHUNT_UN  = 14;
   localparam int          ALM_B_BUS_OV    = 13;
   localparam int          ALM_B_BUS_UN    = 12;
   localparam int          ALM_B_POWER_OV  = 11;
   localparam int          ALM_B_CONV_EN   = 10;
   localparam int          ALM_B_SRC_FLAG  = 4;
   localparam int          ALM_B_DONE_FLAG = 3;
   localparam int          ALM_B_OVF_FLAG  = 2;
   localparam int          ALM_B_LEVEL     = 1;
   localparam int          ALM_B_HOLD      = 0;
   localparam int          ALM_TYPE_W      = 12;
   localparam int          ALM_REV_W       = 4;
   localparam logic [1:0]  ALM_MODE_OFF    = 2'b00;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } alm_reg_req_t;

   typedef struct packed {
      logic        shunt_done;
      logic        bus_done;
      logic        power_done;
      logic        cycle_done;
      logic        math_ovf;
      logic [15:0] shunt_val;
      logic [15:0] bus_val;
      logic [15:0] power_val;
   } alm_meas_t;
endpackage

// File: tb/alm_host_model.sv
// Host side of the alert line: pull-up resistor on an open-collector pin
`timescale 1ns/1ps
`default_nettype none
module alm_host_model (
   input  wire logic i_alert_oe,
   input  wire logic i_alert_out,
   output logic      o_pin
);
   // A released line floats up to the pull-up level, never holds its last value
   assign o_pin = i_alert_oe ? i_alert_out : 1'b1;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the alert limit monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import alm_pkg::*;
   localparam logic [15:0] MK = 16'h3C5A; // Arbitrary maker value
   localparam logic [11:0] DT = 12'h7E4;  // Arbitrary die type value
   localparam logic [3:0]  DR = 4'h9;     // Arbitrary revision value
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   alm_reg_req_t req = '0;
   alm_meas_t    meas = '0;
   logic         cfg_wr = 1'b0;
   logic [2:0]   cfg_mode = 3'b000;
   logic [15:0]  rdata;
   logic         oe;
   logic         aout;
   logic         pin;
   logic         pin_chk = 1'b0;
   logic         rd_seen = 1'b0;
   logic         pin_seen = 1'b0;
   logic [15:0]  exp_q[$];
   logic         pin_q[$];
   int           bad_count = 0;
   int           cmp_count = 0;
   logic [15:0]  r;
   logic [15:0]  viol [5] = '{16'h0020, 16'hFFF0, 16'h8000, 16'h0005, 16'h0011};
   int           qsel [5] = '{0, 0, 1, 1, 2};

   alm_alert_limit_monitor #(.MAKER_CODE(MK), .DIE_TYPE(DT), .DIE_REV(DR))
      alm_alert_limit_monitor_inst (.i_clk(clk), .i_resetn(resetn),
      .i_req(req), .o_rdata(rdata), .i_cfg_wr(cfg_wr), .i_cfg_mode(cfg_mode),
      .i_meas(meas), .o_alert_out(aout), .o_alert_oe(oe));
   alm_host_model alm_host_model_inst (.i_alert_oe(oe), .i_alert_out(aout),
      .o_pin(pin));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Results show one cycle after the request edge, so compare an edge later
   always @(posedge clk) begin
      if (rd_seen) check(rdata, exp_q.pop_front());
      if (pin_seen) check({15'h0, pin}, {15'h0, pin_q.pop_front()});
      rd_seen <= req.rd;
      pin_seen <= pin_chk;
   end

   // A read carries its expected word in d
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      req <= '0;
   endtask

   // q: 0 shunt, 1 bus, 2 power, 3 cycle finished, 4 overflow
   task automatic conv(input int q, input logic [15:0] v);
      @(posedge clk);
      meas <= '{shunt_done: q == 0, bus_done: q == 1, power_done: q == 2,
               cycle_done: q == 3, math_ovf: q == 4, shunt_val: v,
               bus_val: v, power_val: v};
      @(posedge clk);
      meas <= {5'h0, ~v, ~v, ~v};
   endtask

   task automatic pchk(input logic e);
      @(posedge clk);
      pin_chk <= 1'b1;
      pin_q.push_back(e);
      @(posedge clk);
      pin_chk <= 1'b0;
   endtask

   task automatic cfg(input logic [2:0] m);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_mode <= m;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_mode <= ~m;
   endtask

   initial begin
      void'($urandom(32'he2776b78));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      bus(0, ALM_ADDR_MASK, 16'h0000);
      bus(0, ALM_ADDR_THR, 16'h0000);
      bus(0, ALM_ADDR_MAKER, MK);
      bus(0, ALM_ADDR_DIE, {DT, DR});
      bus(0, 8'h10, 16'h0000);
      pchk(1'b1);
      r = 16'($urandom);
      bus(1, ALM_ADDR_THR, r);
      bus(0, ALM_ADDR_THR, r);
      bus(1, ALM_ADDR_MAKER, ~MK);
      bus(0, ALM_ADDR_MAKER, MK);
      bus(1, ALM_ADDR_MASK, 16'hFFFF);
      bus(0, ALM_ADDR_MASK, 16'hFC03);
      bus(1, ALM_ADDR_THR, 16'h0010);
      // Each limit function: equal is no fault, then fault, then recovery
      for (int i = 0; i < 5; i++) begin
         bus(1, ALM_ADDR_MASK, 16'h8000 >> i);
         conv(qsel[i], 16'h0010);
         pchk(1'b1);
         conv(qsel[i], viol[i]);
         pchk(1'b0);
         bus(0, ALM_ADDR_MASK, (16'h8000 >> i) | 16'h0010);
         conv(qsel[i], 16'h0010);
         pchk(1'b1);
         bus(0, ALM_ADDR_MASK, 16'h8000 >> i);
      end
      bus(1, ALM_ADDR_MASK, 16'hF800);
      conv(2, 16'hFFFF);
      conv(1, 16'hFFFF);
      pchk(1'b1);
      conv(0, 16'h0020);
      pchk(1'b0);
      conv(0, 16'h0010);
      // Hold mode with active-high level
      bus(1, ALM_ADDR_MASK, 16'h8003);
      pchk(1'b0);
      conv(0, 16'h0020);
      pchk(1'b1);
      conv(0, 16'h0010);
      pchk(1'b1);
      bus(0, ALM_ADDR_MASK, 16'h8013);
      pchk(1'b0);
      bus(0, ALM_ADDR_MASK, 16'h8003);
      bus(1, ALM_ADDR_MASK, 16'h0000);
      conv(3, 16'h0000);
      bus(0, ALM_ADDR_MASK, 16'h0008);
      bus(0, ALM_ADDR_MASK, 16'h0000);
      for (int m = 0; m < 8; m++) begin
         conv(3, 16'h0000);
         cfg(m[2:0]);
         bus(0, ALM_ADDR_MASK, (m % 4 == 0) ? 16'h0008 : 16'h0000);
      end
      bus(1, ALM_ADDR_MASK, 16'h0400);
      pchk(1'b1);
      conv(3, 16'h0000);
      pchk(1'b0);
      bus(0, ALM_ADDR_MASK, 16'h0408);
      pchk(1'b1);
      conv(4, 16'h0000);
      bus(0, ALM_ADDR_MASK, 16'h0404);
      bus(0, ALM_ADDR_MASK, 16'h0400);
      // A mid-run reset must bring back the active-low follow defaults
      bus(1, ALM_ADDR_MASK, 16'h8003);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      bus(0, ALM_ADDR_MASK, 16'h0000);
      pchk(1'b1);
      repeat (4) @(posedge clk);
      tally_and_finish();
   end

   // The sequence needs well under a thousand cycles
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
